// ### verilog/phb_bridge_cfg.v
// configuration and address translation side of the host bridge
//
// Operation
// - slot register holds slot in bits 4:0
// - abort status register is read only
// - bit 1 mirrors target abort status
// - bit 0 set on master abort
// - inbound map supplies system address 31:28
// - slot numbers run eleven to thirty-one
// - self config header at base plus slot<<11
// - normal config uses own window, same shift
// - top address bits pick one card
// - command bit 2 enables initiator transfers
// - empty slot reads return all ones
// - region 0 is I/O, default one
// - regions 1,2 memory default eight; 3-5 absent
// - interrupt/latency word defaults 0x1FF; subsystem ids zero
// - ROM, cardbus, BIST, line size reserved
// - normal access to own slot becomes self
// - outbound map supplies card address 31:28
// - all map registers reset to zero
`timescale 1ns/1ps
`include "phb_regs.vh"

module phb_bridge_cfg
#(
    parameter [31:0] ID_WORD = 32'h12345678 // arbitrary identity value
)
(
    // clock and reset
    input  wire        ref_clk,
    input  wire        reset,
    input  wire        clk_en,
    // control register port, same clock domain
    input  wire        reg_sel,
    input  wire        reg_write,
    input  wire [11:0] reg_addr,
    input  wire [31:0] reg_wdata,
    output reg  [31:0] reg_rdata,
    // system-side access to the bridge windows, same clock domain
    input  wire        win_valid,
    input  wire        win_write,
    input  wire [31:0] win_addr,
    input  wire [31:0] win_wdata,
    // configuration access issued to the backplane
    output reg         cfg_valid,
    output reg         cfg_write,
    output reg  [31:0] cfg_addr,
    output reg  [31:0] cfg_wdata,
    input  wire        cfg_done,
    input  wire        cfg_no_card,
    input  wire [31:0] cfg_rdata,
    // answer to the system side
    output reg         win_done,
    output reg  [31:0] win_rdata,
    // outbound memory window translation
    input  wire [1:0]  out_region,
    input  wire [27:0] out_offset,
    output wire [31:0] out_pci_addr,
    output wire        out_allowed,
    // inbound translation for backplane masters
    input  wire [1:0]  in_region,
    input  wire [27:0] in_offset,
    output wire [31:0] in_sys_addr,
    // abort events from the bus controller, asynchronous pins
    input  wire        master_abort_pin,
    input  wire        target_abort_pin,
    input  wire        abort_clear
);

    // state codes of the window access engine
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_BUS  = 2'b01;
    localparam [1:0] ST_DONE = 2'b10;

    reg [`PHB_SLOT_MSB:0] own_slot_number_q;
    reg [`PHB_MAP_MSB:0]  omap_q [0:2];
    reg [`PHB_MAP_MSB:0]  imap_q [0:2];
    reg                   master_abort_q;
    reg                   target_abort_q;
    reg [1:0]             ma_sync_q;
    reg [1:0]             ta_sync_q;
    reg [31:0]            stscmd_q;
    reg [31:0]            bar0_q;
    reg [31:0]            bar1_q;
    reg [31:0]            bar2_q;
    reg [31:0]            intlat_q;
    reg [1:0]             state_q;
    reg [31:0]            hdr_rdata;

    // window decode
    wire [7:0]  win_base  = win_addr[31:24];
    wire [4:0]  win_slot  = win_addr[15:11];
    wire [5:0]  win_word  = {win_addr[5:2], 2'b00};
    wire        is_self   = win_base == `PHB_SELFCFG_BASE;
    wire        is_norm   = win_base == `PHB_NORMCFG_BASE;
    wire        slot_ok   = win_slot >= `PHB_SLOT_MIN;
    // self window hits own header; normal hits it if slot matches
    wire        own_hit   = is_self ||
                            (is_norm &&
                             win_slot == own_slot_number_q);
    wire        initiator = stscmd_q[`PHB_CMD_INIT_BIT];

    // abort pins come from the bus controller domain
    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            ma_sync_q <= 2'b00;
            ta_sync_q <= 2'b00;
        end
        else if (clk_en)
        begin
            ma_sync_q <= {ma_sync_q[0], master_abort_pin};
            ta_sync_q <= {ta_sync_q[0], target_abort_pin};
        end
    end

    // sticky abort flags, a new event beats a clear in the same cycle
    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            master_abort_q <= 1'b0;
            target_abort_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (ma_sync_q[1])
                master_abort_q <= 1'b1;
            else if (abort_clear)
                master_abort_q <= 1'b0;
            if (ta_sync_q[1])
                target_abort_q <= 1'b1;
            else if (abort_clear)
                target_abort_q <= 1'b0;
        end
    end

    // control register writes; flags are not writable
    always @(posedge ref_clk or posedge reset)
    begin : ctl_wr
        integer i;
        if (reset)
        begin
            own_slot_number_q <= 5'h00;
            for (i = 0; i < 3; i = i + 1)
            begin
                omap_q[i] <= `PHB_MAP_RESET;
                imap_q[i] <= `PHB_MAP_RESET;
            end
        end
        else if (clk_en && reg_sel && reg_write)
        begin
            case (reg_addr)
                `PHB_OFS_OMAP0: omap_q[0] <= reg_wdata[3:0];
                `PHB_OFS_OMAP1: omap_q[1] <= reg_wdata[3:0];
                `PHB_OFS_OMAP2: omap_q[2] <= reg_wdata[3:0];
                `PHB_OFS_SLOT:  own_slot_number_q <= reg_wdata[4:0];
                `PHB_OFS_IMAP0: imap_q[0] <= reg_wdata[3:0];
                `PHB_OFS_IMAP1: imap_q[1] <= reg_wdata[3:0];
                `PHB_OFS_IMAP2: imap_q[2] <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    // control register read mux, reserved bits read zero
    always @*
    begin
        case (reg_addr)
            `PHB_OFS_OMAP0: reg_rdata = {28'h0000000, omap_q[0]};
            `PHB_OFS_OMAP1: reg_rdata = {28'h0000000, omap_q[1]};
            `PHB_OFS_OMAP2: reg_rdata = {28'h0000000, omap_q[2]};
            `PHB_OFS_SLOT:  reg_rdata = {27'h0000000,
                                         own_slot_number_q};
            `PHB_OFS_FLAGS: reg_rdata = {30'h00000000, target_abort_q,
                                         master_abort_q};
            `PHB_OFS_IMAP0: reg_rdata = {28'h0000000, imap_q[0]};
            `PHB_OFS_IMAP1: reg_rdata = {28'h0000000, imap_q[1]};
            `PHB_OFS_IMAP2: reg_rdata = {28'h0000000, imap_q[2]};
            default:        reg_rdata = 32'h00000000;
        endcase
    end

    // translation; region 3 has no map and yields a zero nibble
    assign out_pci_addr = {(out_region == 2'b11) ? 4'h0 :
                           omap_q[out_region], out_offset};
    assign in_sys_addr  = {(in_region == 2'b11) ? 4'h0 :
                           imap_q[in_region], in_offset};
    assign out_allowed  = initiator;

    // own header read; absent words read zero
    always @*
    begin
        case (win_word)
            `PHB_HDR_ID:      hdr_rdata = ID_WORD;
            `PHB_HDR_STSCMD:  hdr_rdata = stscmd_q;
            `PHB_HDR_CLASS:   hdr_rdata = `PHB_RST_CLASS;
            `PHB_HDR_HDRTYPE: hdr_rdata = `PHB_RST_HDRTYPE;
            `PHB_HDR_BAR0:    hdr_rdata = bar0_q;
            `PHB_HDR_BAR1:    hdr_rdata = bar1_q;
            `PHB_HDR_BAR2:    hdr_rdata = bar2_q;
            `PHB_HDR_SUBSYS:  hdr_rdata = `PHB_RST_ZERO;
            `PHB_HDR_CFG_CAPABILITY_POINTER:  hdr_rdata = `PHB_RST_ZERO;
            `PHB_HDR_INTLAT:  hdr_rdata = intlat_q;
            default:          hdr_rdata = `PHB_RST_ZERO;
        endcase
    end

    // own header writes; type bits of each region stay fixed
    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            stscmd_q <= `PHB_RST_STSCMD;
            bar0_q   <= `PHB_RST_BAR0;
            bar1_q   <= `PHB_RST_BAR1;
            bar2_q   <= `PHB_RST_BAR2;
            intlat_q <= `PHB_RST_INTLAT;
        end
        else if (clk_en && state_q == ST_IDLE && win_valid &&
                 win_write && own_hit)
        begin
            case (win_word)
                `PHB_HDR_STSCMD: stscmd_q <= {stscmd_q[31:16],
                                              win_wdata[15:0]};
                `PHB_HDR_BAR0:   bar0_q <= {win_wdata[31:2], 2'b01};
                `PHB_HDR_BAR1:   bar1_q <= {win_wdata[31:4], 4'h8};
                `PHB_HDR_BAR2:   bar2_q <= {win_wdata[31:4], 4'h8};
                `PHB_HDR_INTLAT: intlat_q <= {intlat_q[31:8],
                                              win_wdata[7:0]};
                default: ;
            endcase
        end
    end

    // window engine: own header answers locally, others go to the bus when the initiator bit is set and the slot is eleven or more
    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q   <= ST_IDLE;
            cfg_valid <= 1'b0;
            cfg_write <= 1'b0;
            cfg_addr  <= 32'h00000000;
            cfg_wdata <= 32'h00000000;
            win_done  <= 1'b0;
            win_rdata <= 32'h00000000;
        end
        else if (clk_en)
        begin
            win_done <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (win_valid && (is_self || is_norm))
                    begin
                        if (own_hit)
                        begin
                            win_rdata <= hdr_rdata;
                            win_done  <= 1'b1;
                            state_q   <= ST_DONE;
                        end
                        else if (!slot_ok || !initiator)
                        begin
                            // no card reachable: empty-slot answer
                            win_rdata <= `PHB_ALL_ONES;
                            win_done  <= 1'b1;
                            state_q   <= ST_DONE;
                        end
                        else
                        begin
                            // slot bit drives its IDSEL line
                            cfg_addr  <= (32'h00000001 << win_slot) |
                                         {21'h000000,
                                          win_addr[10:0]};
                            cfg_write <= win_write;
                            cfg_wdata <= win_wdata;
                            cfg_valid <= 1'b1;
                            state_q   <= ST_BUS;
                        end
                    end
                end
                ST_BUS:
                begin
                    if (cfg_done)
                    begin
                        cfg_valid <= 1'b0;
                        win_rdata <= cfg_no_card ? `PHB_ALL_ONES
                                                 : cfg_rdata;
                        win_done  <= 1'b1;
                        state_q   <= ST_DONE;
                    end
                end
                ST_DONE:
                    // one idle cycle lets the requester drop valid
                    state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

endmodule // phb_bridge_cfg

// ### verilog/phb_regs.vh
// register offsets, field positions and reset values of the host bridge
`ifndef PHB_REGS_VH
`define PHB_REGS_VH

// control register block, byte offsets from the block base
`define PHB_OFS_OMAP0     12'h000
`define PHB_OFS_OMAP1     12'h004
`define PHB_OFS_OMAP2     12'h008
`define PHB_OFS_SLOT      12'h00C
`define PHB_OFS_FLAGS     12'h010
`define PHB_OFS_IMAP0     12'h014
`define PHB_OFS_IMAP1     12'h018
`define PHB_OFS_IMAP2     12'h01C
`define PHB_MAP_RESET     4'h0

// field positions
`define PHB_SLOT_MSB      4
`define PHB_MAP_MSB       3
`define PHB_FLAG_MASTER   0
`define PHB_FLAG_TARGET   1
`define PHB_CMD_INIT_BIT  2

// window bases and slot decode
`define PHB_SELFCFG_BASE  8'h41
`define PHB_NORMCFG_BASE  8'h42
`define PHB_SLOT_SHIFT    11
`define PHB_SLOT_MIN      5'h0B
`define PHB_SLOT_MAX      5'h1F

// own configuration header word offsets
`define PHB_HDR_ID        6'h00
`define PHB_HDR_STSCMD    6'h04
`define PHB_HDR_CLASS     6'h08
`define PHB_HDR_HDRTYPE   6'h0C
`define PHB_HDR_BAR0      6'h10
`define PHB_HDR_BAR1      6'h14
`define PHB_HDR_BAR2      6'h18
`define PHB_HDR_SUBSYS    6'h2C
`define PHB_HDR_CFG_CAPABILITY_POINTER    6'h34
`define PHB_HDR_INTLAT    6'h3C

// header reset values
`define PHB_RST_STSCMD    32'h02200000
`define PHB_RST_CLASS     32'h0B400000
`define PHB_RST_HDRTYPE   32'h00000000
`define PHB_RST_BAR0      32'h00000001
`define PHB_RST_BAR1      32'h00000008
`define PHB_RST_BAR2      32'h00000008
`define PHB_RST_ZERO      32'h00000000
`define PHB_RST_INTLAT    32'h000001FF
`define PHB_ALL_ONES      32'hFFFFFFFF

`endif

// ### verif/phb_cfg_chk_sva.sv
// checker of the host bridge configuration ports
`timescale 1ns/1ps
module phb_cfg_chk
(
    // clock and reset
    input wire        ref_clk,
    input wire        reset,
    input wire        clk_en,
    // register and window side
    input wire [11:0] reg_addr,
    input wire [31:0] reg_rdata,
    input wire        win_valid,
    input wire [31:0] win_addr,
    input wire        win_done,
    // backplane side
    input wire        cfg_valid,
    input wire [31:0] cfg_addr,
    input wire        cfg_done,
    // translation and aborts
    input wire [27:0] out_offset,
    input wire [31:0] out_pci_addr,
    input wire [27:0] in_offset,
    input wire [31:0] in_sys_addr,
    input wire        master_abort_pin
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    // maps only replace the top nibble, offsets pass untouched
    chk_in_offset: assert property (in_sys_addr[27:0] == in_offset)
        else $error("inbound offset altered");
    chk_out_offset: assert property (out_pci_addr[27:0] == out_offset)
        else $error("outbound offset altered");
    // one idsel line per access, picked by the slot field
    chk_cfg_addr: assert property (cfg_valid |->
        cfg_addr == ((32'h1 << win_addr[15:11]) | win_addr[10:0]))
        else $error("config address not one-hot slot");
    chk_done_answer: assert property (cfg_valid && cfg_done && clk_en
        |=> win_done && !cfg_valid)
        else $error("bus answer not returned next cycle");
    // self window accesses never go out on the backplane
    chk_self_local: assert property (win_valid &&
        win_addr[31:24] == 8'h41 |-> !cfg_valid)
        else $error("self access reached backplane");
    chk_flags_rsvd: assert property (reg_addr == 12'h010 |->
        reg_rdata[31:2] == 30'h0)
        else $error("abort flags reserved bits set");
    chk_slot_rsvd: assert property (reg_addr == 12'h00C |->
        reg_rdata[31:5] == 27'h0)
        else $error("slot reserved bits set");
    // two synchroniser edges and the flag edge, then the flag shows while addressed
    chk_abort_set: assert property ((master_abort_pin && clk_en)[*3]
        |=> reg_addr != 12'h010 || reg_rdata[0])
        else $error("master abort flag late");
endmodule // phb_cfg_chk

bind phb_bridge_cfg phb_cfg_chk u_phb_cfg_chk (.*);

// ### verif/phb_card_model.sv
// behavioural backplane of cards answering configuration accesses
`timescale 1ns/1ps
module phb_card_model
#(
    parameter [31:0] CARD_MASK = 32'h40001000,
    parameter [31:0] CARD_ID   = 32'h5A5A0000 // arbitrary card identity
)
(
    // clock and reset
    input  wire        ref_clk,
    input  wire        reset,
    // configuration access from the bridge
    input  wire        cfg_valid,
    input  wire [31:0] cfg_addr,
    output reg         cfg_done,
    output reg         cfg_no_card,
    output reg  [31:0] cfg_rdata
);
    reg     [2:0] wait_q;
    reg           slow_q;
    reg     [4:0] slot;
    integer       i;

    // a card sees only its own idsel line
    always @*
    begin
        slot = 5'h00;
        for (i = 11; i < 32; i = i + 1)
            if (cfg_addr[i]) slot = i[4:0];
    end

    // alternate prompt and slow answers; released data stays put only while a slow answer waits
    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            wait_q      <= 3'h0;
            slow_q      <= 1'b0;
            cfg_done    <= 1'b0;
            cfg_no_card <= 1'b0;
            cfg_rdata   <= 32'h0;
        end
        else if (cfg_done)
        begin
            cfg_done    <= 1'b0;
            cfg_no_card <= 1'b0;
            cfg_rdata   <= ~cfg_rdata;
            slow_q      <= ~slow_q;
        end
        else if (cfg_valid && (wait_q == 3'h3 || !slow_q))
        begin
            wait_q      <= 3'h0;
            cfg_done    <= 1'b1;
            cfg_no_card <= !CARD_MASK[slot];
            cfg_rdata   <= CARD_MASK[slot] ? CARD_ID | slot : 32'hFFFFFFFF;
        end
        else if (cfg_valid)
            wait_q <= wait_q + 3'h1;
        else
            cfg_rdata <= ~cfg_rdata;
    end
endmodule // phb_card_model

// ### verif/phb_bridge_cfg_tb.sv
// self-checking bench of the host bridge configuration block
`timescale 1ns/1ps
module phb_bridge_cfg_tb;
    reg         ref_clk, reset, clk_en, reg_sel, reg_write, win_valid;
    reg         win_write, master_abort_pin, target_abort_pin, abort_clear;
    reg  [11:0] reg_addr;
    reg  [31:0] reg_wdata, win_addr, win_wdata, rdat, v, seed;
    reg  [1:0]  out_region, in_region;
    reg  [27:0] out_offset, in_offset;
    reg  [3:0]  mv [0:7];
    wire [31:0] reg_rdata, cfg_addr, cfg_wdata, cfg_rdata, win_rdata;
    wire [31:0] out_pci_addr, in_sys_addr;
    wire        cfg_valid, cfg_write, cfg_done, cfg_no_card, win_done;
    wire        out_allowed;
    integer     k, n, mismatches, comparisons;

    phb_bridge_cfg u_phb_bridge_cfg (.*);
    phb_card_model u_phb_card_model (.*);

    always #5 ref_clk = ~ref_clk;

    task chk(input [31:0] got, input [31:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask

    // one register cycle; read data is combinational
    task reg_op(input w, input [11:0] a, input [31:0] d);
    begin
        @(negedge ref_clk);
        {reg_sel, reg_write, reg_addr, reg_wdata} = {1'b1, w, a, d};
        #1 rdat = reg_rdata;
        @(negedge ref_clk);
        reg_sel = 1'b0;
    end
    endtask

    // window request held until the done pulse, bounded wait
    task win(input [31:0] a, input w, input [31:0] d);
    begin
        @(negedge ref_clk);
        {win_valid, win_write, win_addr, win_wdata} = {1'b1, w, a, d};
        for (n = 0; n < 50 && win_done !== 1'b1; n = n + 1)
            @(negedge ref_clk);
        rdat = win_rdata;
        win_valid = 1'b0;
    end
    endtask

    function [31:0] exp_hdr(input [5:0] o);
        case (o)
        6'h00: exp_hdr = 32'h12345678;
        6'h04: exp_hdr = 32'h02200000;
        6'h08: exp_hdr = 32'h0B400000;
        6'h10: exp_hdr = 32'h00000001;
        6'h14, 6'h18: exp_hdr = 32'h00000008;
        6'h3C: exp_hdr = 32'h000001FF;
        default: exp_hdr = 32'h0;
        endcase
    endfunction

    function [31:0] exp_slot(input [4:0] s);
        if (s == 5'd29) exp_slot = 32'h12345678;
        else if (s == 5'd12 || s == 5'd30) exp_slot = 32'h5A5A0000 | s;
        else exp_slot = 32'hFFFFFFFF;
    endfunction

    task final_report;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask

    // cut a hang well past the expected few hundred cycles
    initial
    begin
        #300000;
        mismatches = mismatches + 1;
        final_report;
    end

    initial
    begin
        {ref_clk, reset, clk_en, reg_sel, reg_write, win_valid} = 6'h18;
        {win_write, master_abort_pin, target_abort_pin, abort_clear} = 4'h0;
        {reg_addr, reg_wdata, win_addr, win_wdata} = 108'h0;
        {out_region, in_region, out_offset, in_offset} = 60'h0;
        {mismatches, comparisons, seed} = {32'h0, 32'h0, 32'hBBFB};
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk) reset = 1'b0;
        for (k = 0; k < 8; k = k + 1)
        begin
            reg_op(1'b0, {k[9:0], 2'b00}, 32'h0);
            chk(rdat, 32'h0);
        end
        $display("test reset done");
        for (k = 0; k < 16; k = k + 1)
        begin
            win(32'h4100E800 | {k[5:0], 2'b00}, 1'b0, 32'h0);
            chk(rdat, exp_hdr({k[3:0], 2'b00}));
        end
        $display("test header done");
        for (k = 0; k < 8; k = k + 1)
        begin
            v = $random(seed);
            mv[k] = (k == 4) ? 4'h0 : v[3:0];
            reg_op(1'b1, {k[9:0], 2'b00}, v);
            reg_op(1'b0, {k[9:0], 2'b00}, 32'h0);
            chk(rdat, (k == 3) ? {27'h0, v[4:0]} : {28'h0, mv[k]});
        end
        for (k = 0; k < 3; k = k + 1)
        begin
            {out_region, in_region} = {k[1:0], k[1:0]};
            {out_offset, in_offset} = {$random(seed), $random(seed)};
            #1 chk(out_pci_addr, {mv[k], out_offset});
            chk(in_sys_addr, {mv[k + 5], in_offset});
        end
        $display("test maps done");
        reg_op(1'b1, 12'h00C, 32'd29);
        win(32'h4200F000, 1'b0, 32'h0);
        chk(rdat, 32'hFFFFFFFF);
        chk({31'h0, out_allowed}, 32'h0);
        win(32'h4100E804, 1'b1, 32'h4);
        win(32'h4100E804, 1'b0, 32'h0);
        chk(rdat, 32'h02200004);
        chk({31'h0, out_allowed}, 32'h1);
        for (k = 11; k < 32; k = k + 1)
        begin
            win(32'h42000000 | (k << 11), 1'b0, 32'h0);
            chk(rdat, exp_slot(k[4:0]));
        end
        $display("test scan done");
        // software reprograms an outbound map by read-modify-write
        reg_op(1'b0, 12'h000, 32'h0);
        reg_op(1'b1, 12'h000, {rdat[31:4], 4'hA});
        reg_op(1'b0, 12'h000, 32'h0);
        chk(rdat, 32'h0000000A);
        out_region = 2'b00;
        #1 chk(out_pci_addr, {4'hA, out_offset});
        // flags latch a pulse and hold it after the pin drops
        master_abort_pin = 1'b1;
        repeat (4) @(negedge ref_clk);
        {master_abort_pin, target_abort_pin} = 2'b01;
        repeat (4) @(negedge ref_clk);
        target_abort_pin = 1'b0;
        repeat (4) @(negedge ref_clk);
        reg_op(1'b0, 12'h010, 32'h0);
        chk(rdat, 32'h3);
        abort_clear = 1'b1;
        @(negedge ref_clk) abort_clear = 1'b0;
        reg_op(1'b0, 12'h010, 32'h0);
        chk(rdat, 32'h0);
        $display("test aborts done");
        final_report;
    end
endmodule // phb_bridge_cfg_tb
